// [src/interval_timer_map.vh]
/*
 * register offsets, control field positions, reset values and prescale ratios of the interval timer.
 * assumes the including file sits on a 32-bit apb with byte addresses.
 */
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH

`define COUNT_VALUE_OFFSET 12'h100
`define PERIOD_VALUE_OFFSET 12'h102
`define TIMER_CONTROL_OFFSET 12'h104
`define IRQ_STATUS_OFFSET 12'h108
`define COUNT_VALUE_ADDR 12'h400
`define PERIOD_VALUE_ADDR 12'h408
`define TIMER_CONTROL_ADDR 12'h410
`define IRQ_STATUS_ADDR 12'h420

`define PERIOD_VALUE_RESET 16'hffff
`define TIMER_CONTROL_RESET 16'h0000
`define TIMER_CONTROL_MASK 16'ha076

`define CTL_TIMER_ON 15
`define CTL_STOP_IN_IDLE 13
`define CTL_GATE_ACCUMULATE 6
`define CTL_PRESCALE_HI 5
`define CTL_PRESCALE_LO 4
`define CTL_EXT_SYNC 2
`define CTL_CLOCK_SOURCE 1

`define IRQ_MATCH_FLAG 0
`define IRQ_MATCH_ENABLE 1

`define PRESCALE_DIV1 8'h00
`define PRESCALE_DIV8 8'h07
`define PRESCALE_DIV64 8'h3f
`define PRESCALE_DIV256 8'hff

`endif

// [src/edge_sync.v]
/*
 * two-flop synchroniser with rising and falling edge pulses.
 * assumes the input is asynchronous to pclk; all state frozen while ce is low.
 */
`timescale 1ns/1ps
module edge_sync (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire async_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule

// [src/interval_timer_16bit.v]
/*
 * interval_timer_16bit: 16-bit timer/counter with prescaler, period match and apb register access.
 * assumes one pclk domain at 250 mhz, cpu idle/sleep given as plain same-clock levels, and the
 * external count pin asynchronous to pclk.
 */
`timescale 1ns/1ps
`include "interval_timer_map.vh"
module interval_timer_16bit (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire cpu_idle,
    input wire cpu_sleep,
    input wire external_count_input,
    output wire match_irq
);
    reg [15:0] count_value_q;
    reg [15:0] period_value_q;
    reg [15:0] timer_control_q;
    reg match_flag_q;
    reg match_irq_enable_q;
    reg [7:0] prescale_q;
    reg [7:0] prescale_d;

    wire ext_level;
    wire ext_rise;
    wire ext_fall;
    wire access_en;
    wire wr_en;
    wire wr_count;
    wire wr_control;
    wire wr_status;
    wire timer_on;
    wire stop_in_idle;
    wire gate_accumulate_enable;
    wire external_sync_select;
    wire clock_source_select;
    wire [1:0] prescale_select;
    wire [7:0] prescale_limit;
    wire halted;
    wire source_tick;
    wire prescale_tick;
    wire at_period;
    wire gate_end;
    wire addr_hit;

    // prescale ratio as terminal count of the divider
    function [7:0] ratio_limit;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: ratio_limit = `PRESCALE_DIV1;
                2'b01: ratio_limit = `PRESCALE_DIV8;
                2'b10: ratio_limit = `PRESCALE_DIV64;
                default: ratio_limit = `PRESCALE_DIV256;
            endcase
        end
    endfunction

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `COUNT_VALUE_ADDR) || (a == `PERIOD_VALUE_ADDR) ||
                        (a == `TIMER_CONTROL_ADDR) || (a == `IRQ_STATUS_ADDR);
        end
    endfunction

    // the pin is the clock in async mode; here it is still synchronised, the difference being only
    // that async counting survives sleep, since a real async path has no pclk dependency
    edge_sync u_ext (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(external_count_input),
        .level(ext_level),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    assign timer_on = timer_control_q[`CTL_TIMER_ON];
    assign stop_in_idle = timer_control_q[`CTL_STOP_IN_IDLE];
    assign gate_accumulate_enable = timer_control_q[`CTL_GATE_ACCUMULATE];
    assign external_sync_select = timer_control_q[`CTL_EXT_SYNC];
    assign clock_source_select = timer_control_q[`CTL_CLOCK_SOURCE];
    assign prescale_select = timer_control_q[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
    assign prescale_limit = ratio_limit(prescale_select);

    // sleep stops every source except the unsynced external one
    assign halted = (cpu_idle & stop_in_idle) |
                    (cpu_sleep & ~(clock_source_select & ~external_sync_select));

    // select the raw tick: external pin rise, or instruction cycle, optionally gated
    assign source_tick = clock_source_select ? ext_rise :
                         (gate_accumulate_enable ? ext_level : 1'b1);

    assign prescale_tick = timer_on & ~halted & source_tick & (prescale_q == prescale_limit);
    assign at_period = (count_value_q == period_value_q);
    assign gate_end = timer_on & ~clock_source_select & gate_accumulate_enable & ext_fall & ~halted;

    assign access_en = psel & penable;
    assign wr_en = access_en & pwrite;
    assign wr_count = wr_en & (paddr == `COUNT_VALUE_ADDR);
    assign wr_control = wr_en & (paddr == `TIMER_CONTROL_ADDR);
    assign wr_status = wr_en & (paddr == `IRQ_STATUS_ADDR);
    assign addr_hit = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = access_en & ~addr_hit;

    // prescaler only moves while the timer is on, so its clears are lost when off
    always @* begin
        prescale_d = prescale_q;
        if (timer_on) begin
            if (wr_count || (wr_control && !pwdata[`CTL_TIMER_ON])) begin
                prescale_d = 8'h00;
            end else if (!halted && source_tick) begin
                prescale_d = (prescale_q >= prescale_limit) ? 8'h00 : prescale_q + 8'h01;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= 8'h00;
        end else if (ce) begin
            prescale_q <= prescale_d;
        end
    end

    // count: only a count write loads it; a control write leaves it untouched
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_q <= 16'h0000;
        end else if (ce) begin
            if (wr_count) begin
                count_value_q <= pwdata[15:0];
            end else if (prescale_tick) begin
                if (at_period) begin
                    count_value_q <= 16'h0000;
                end else begin
                    count_value_q <= count_value_q + 16'h0001;
                end
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value_q <= `PERIOD_VALUE_RESET;
            timer_control_q <= `TIMER_CONTROL_RESET;
            match_irq_enable_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && paddr == `PERIOD_VALUE_ADDR) begin
                period_value_q <= pwdata[15:0];
            end
            if (wr_control) begin
                timer_control_q <= pwdata[15:0] & `TIMER_CONTROL_MASK;
            end
            if (wr_status) begin
                match_irq_enable_q <= pwdata[`IRQ_MATCH_ENABLE];
            end
        end
    end

    // flag: set wins over a software clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_flag_q <= 1'b0;
        end else if (ce) begin
            if ((prescale_tick && at_period) || gate_end) begin
                match_flag_q <= 1'b1;
            end else if (wr_status && !pwdata[`IRQ_MATCH_FLAG]) begin
                match_flag_q <= 1'b0;
            end
        end
    end

    assign match_irq = match_flag_q & match_irq_enable_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `COUNT_VALUE_ADDR: prdata <= {16'h0000, count_value_q};
                    `PERIOD_VALUE_ADDR: prdata <= {16'h0000, period_value_q};
                    `TIMER_CONTROL_ADDR: prdata <= {16'h0000, timer_control_q};
                    `IRQ_STATUS_ADDR: prdata <= {30'h0000_0000, match_irq_enable_q, match_flag_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// [tb/timer_checker_assertions.sv]
/* port checker for the interval timer.
   assumes the map header is on the include path. */
`timescale 1ns/1ps
`include "interval_timer_map.vh"
module timer_checker (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire match_irq
);
    wire acc = ce & psel & penable;
    wire rd = acc & ~pwrite;
    wire wirq = acc & pwrite & (paddr == `IRQ_STATUS_ADDR);
    wire hit = paddr == `COUNT_VALUE_ADDR || paddr == `PERIOD_VALUE_ADDR || paddr == `TIMER_CONTROL_ADDR ||
        paddr == `IRQ_STATUS_ADDR;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_zero_wait_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (acc && !hit |-> pslverr) else $error("no slave error");
    mapped_ok_a: assert property (acc && hit |-> !pslverr) else $error("false slave error");
    unmapped_zero_a: assert property (rd && !hit |-> prdata == 32'h0000_0000) else $error("unmapped data");
    ctl_reserved_a: assert property (rd && paddr == `TIMER_CONTROL_ADDR |->
        (prdata[15:0] & ~`TIMER_CONTROL_MASK) == 16'h0000 && prdata[31:16] == 16'h0000)
        else $error("reserved bits set");
    count_width_a: assert property (rd && paddr == `COUNT_VALUE_ADDR |-> prdata[31:16] == 16'h0000)
        else $error("count too wide");
    irq_sticky_a: assert property (match_irq && !wirq |=> match_irq) else $error("flag lost");
    irq_off_a: assert property (wirq && !pwdata[1] |=> !match_irq) else $error("irq not masked");
    reset_quiet_a: assert property ($rose(presetn) |-> !match_irq) else $error("irq after reset");
endmodule
bind interval_timer_16bit timer_checker chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .match_irq(match_irq));

// [tb/pin_source.sv]
/* external count pin model: bursts of pulses.
   assumes go is a pulse; pin idles low, off the clock phase. */
`timescale 1ns/1ps
module pin_source (
    input wire pclk,
    input wire go,
    input wire [7:0] count,
    input wire [7:0] half,
    output reg pin,
    output reg busy
);
    integer i;
    initial pin = 1'b0;
    initial busy = 1'b0;
    always @(posedge go) begin
        busy = 1'b1;
        for (i = 0; i < count; i = i + 1) begin
            repeat (half) @(posedge pclk);
            #1.3 pin = 1'b1;
            repeat (half) @(posedge pclk);
            #1.3 pin = 1'b0;
        end
        busy = 1'b0;
    end
endmodule

// [tb/testbench.sv]
/* self-checking bench for the interval timer over apb.
   assumes zero-wait apb and the pin model on the count input. */
`timescale 1ns/1ps
`include "interval_timer_map.vh"
module testbench;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg idle = 1'b0, sleep = 1'b0, go = 1'b0, ce = 1'b1;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000, got, c;
    reg [7:0] npul = 8'h00, half = 8'h04;
    wire [31:0] prdata;
    wire pready, pslverr, irq, pin, busy;
    integer n_fail = 0, total_checks = 0, seed = 49, i, k, n, dv;
    always #2 pclk = ~pclk;
    interval_timer_16bit uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_idle(idle), .cpu_sleep(sleep), .external_count_input(pin), .match_irq(irq));
    pin_source src (.pclk(pclk), .go(go), .count(npul), .half(half), .pin(pin), .busy(busy));
    task complete_run; begin
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end endtask
    task chk(input [8*6:1] nm, input integer lo, input integer hi, input [31:0] v); begin
        total_checks = total_checks + 1;
        if (^v === 1'bx || v < lo || v > hi) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0s expected %0d..%0d seen %0h", nm, lo, hi, v);
        end
    end endtask
    // one idle edge first so back-to-back calls never drive psel twice in a step
    task apb(input w, input [11:0] a, input [31:0] d); begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        got = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    end endtask
    task rd(input [8*6:1] nm, input [11:0] a, input integer lo, input integer hi); begin
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, lo, hi, got);
    end endtask
    task pulses(input integer cnt); begin
        npul <= cnt[7:0];
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy) @(posedge pclk);
        repeat (8) @(posedge pclk);
    end endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd("period", `PERIOD_VALUE_ADDR, 65535, 65535);
        rd("ctrl", `TIMER_CONTROL_ADDR, 0, 0);
        rd("unmap", 12'h00c, 0, 0);
        apb(1'b1, `COUNT_VALUE_ADDR, 32'h0000_1234);
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_2076);
        rd("count", `COUNT_VALUE_ADDR, 4660, 4660);
        for (i = 0; i < 4; i = i + 1) begin
            dv = (i == 3) ? 256 : 1 << (3 * i);
            apb(1'b1, `COUNT_VALUE_ADDR, 32'h0000_0000);
            apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_8000 | (i << 4));
            repeat (5 * dv - 3) @(posedge pclk);
            apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_0000);
            rd("scaled", `COUNT_VALUE_ADDR, 4, 6);
        end
        // sync asleep, sync awake, async asleep, async idle with stop bit
        for (i = 0; i < 4; i = i + 1) begin
            c = (i < 2) ? 32'h0000_8006 : (i == 2 ? 32'h0000_8002 : 32'h0000_a002);
            n = 1 + ($random(seed) & 7);
            sleep <= (i != 1 && i != 3);
            idle <= (i == 3);
            apb(1'b1, `COUNT_VALUE_ADDR, 32'h0000_0000);
            apb(1'b1, `TIMER_CONTROL_ADDR, c);
            pulses(n);
            apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_0000);
            rd("extcnt", `COUNT_VALUE_ADDR, (i == 1 || i == 2) ? n : 0, (i == 1 || i == 2) ? n : 0);
        end
        idle <= 1'b0;
        sleep <= 1'b0;
        apb(1'b1, `PERIOD_VALUE_ADDR, 32'h0000_0003);
        apb(1'b1, `IRQ_STATUS_ADDR, 32'h0000_0002);
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_8000);
        for (i = 0; i < 4; i = i + 1) rd("wrap", `COUNT_VALUE_ADDR, 0, 3);
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_0000);
        rd("flag", `IRQ_STATUS_ADDR, 3, 3);
        chk("irqpin", 1, 1, {31'h0000_0000, irq});
        apb(1'b1, `IRQ_STATUS_ADDR, 32'h0000_0002);
        rd("clear", `IRQ_STATUS_ADDR, 2, 2);
        apb(1'b1, `PERIOD_VALUE_ADDR, 32'h0000_ffff);
        apb(1'b1, `COUNT_VALUE_ADDR, 32'h0000_0000);
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_8040);
        half <= 8'h28;
        pulses(1);
        rd("gated", `COUNT_VALUE_ADDR, 38, 42);
        rd("gfall", `IRQ_STATUS_ADDR, 3, 3);
        // clock enable low must freeze the running count: only the ticks after release may land
        apb(1'b1, `COUNT_VALUE_ADDR, 32'h0000_0000);
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_8000);
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b1, `TIMER_CONTROL_ADDR, 32'h0000_0000);
        rd("ceheld", `COUNT_VALUE_ADDR, 2, 4);
        complete_run;
    end
endmodule
